/* testbench.sv */
// Testbench: AHB-Lite register tests of the OUT endpoint config/count bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	import uoe_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, rx_valid, rx_accept, dbuf, iso, ready_flag, irq;
	logic [9:0] rx_len;
	int mismatches = 0;
	int check_count = 0;
	always #5 hclk = ~hclk;
	uoe_endpoint_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
		.rx_len(rx_len), .rx_accept(rx_accept), .out_double_buffer_enable(dbuf),
		.out_iso_mode(iso), .out_packet_ready_flag(ready_flag), .irq(irq));
	uoe_usb_host host (.hclk(hclk), .rx_accept(rx_accept), .rx_valid(rx_valid), .rx_len(rx_len));
	// No wait count is assumed: the slave's ready paces both phases
	task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
		@(posedge hclk);
		haddr <= {22'h000000, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK(hresp, 1'b0)
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(idx, 1'b1, d);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		xfer(idx, 1'b0, 32'h0);
		`CHK(rd, exp)
	endtask
	task automatic wait_flag();
		for (int i = 0; i < 20 && ready_flag !== 1'b1; i++) @(posedge hclk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge hclk);
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk(IDX_CONTROL_HIGH, 32'h0);
		rdchk(IDX_COUNT_LOW, 32'h0);
		rdchk(IDX_COUNT_HIGH, 32'h0);
		$display("test reset values done");
		for (int i = 3; i >= 0; i--) begin
			wr(IDX_CONTROL_HIGH, {24'h0, i[1:0], 6'h3F});
			rdchk(IDX_CONTROL_HIGH, {24'h0, i[1:0], 6'h00});
			`CHK({dbuf, iso}, i[1:0])
		end
		wr(IDX_COUNT_LOW, 32'hFFFFFFFF);
		wr(IDX_COUNT_HIGH, 32'hFFFFFFFF);
		rdchk(IDX_COUNT_LOW, 32'h0);
		rdchk(IDX_COUNT_HIGH, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rdchk(8'h30, 32'h0);
		$display("test control and read-only bits done");
		wr(IDX_IRQ_ENABLE, 32'h1);
		host.send(10'h2A5);
		wait_flag();
		`CHK(irq, 1'b1)
		rdchk(IDX_COUNT_LOW, 32'hA5);
		rdchk(IDX_COUNT_HIGH, 32'h2);
		rdchk(IDX_PKT_STATUS, 32'h1);
		wr(IDX_IRQ_ENABLE, 32'h0);
		rdchk(IDX_IRQ_STATUS, 32'h1);
		`CHK(irq, 1'b0)
		wr(IDX_IRQ_CLEAR, 32'h1);
		rdchk(IDX_IRQ_STATUS, 32'h0);
		wr(IDX_IRQ_ENABLE, 32'h1);
		wr(IDX_PKT_STATUS, 32'h0);
		rdchk(IDX_PKT_STATUS, 32'h0);
		$display("test single packet done");
		// Both packets must be accepted before software touches the first
		wr(IDX_CONTROL_HIGH, 32'h80);
		host.send(10'h3FF);
		host.send(10'h001);
		wait_flag();
		rdchk(IDX_COUNT_LOW, 32'hFF);
		rdchk(IDX_COUNT_HIGH, 32'h3);
		wr(IDX_IRQ_CLEAR, 32'h1);
		wr(IDX_PKT_STATUS, 32'h0);
		repeat (4) @(posedge hclk);
		`CHK(ready_flag, 1'b1)
		`CHK(irq, 1'b1)
		rdchk(IDX_COUNT_LOW, 32'h01);
		rdchk(IDX_COUNT_HIGH, 32'h0);
		rdchk(IDX_IRQ_STATUS, 32'h1);
		$display("test double buffer done");
		stop_test();
	end
endmodule // testbench
`default_nettype wire

/* uoe_endpoint_regs.sv */
// Top: AHB-Lite register bank for one OUT endpoint's config and received count
`timescale 1ns/1ps
`default_nettype none
module uoe_endpoint_regs
	import uoe_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rx_valid,
	input wire logic [9:0] rx_len,
	output logic rx_accept,
	output logic out_double_buffer_enable,
	output logic out_iso_mode,
	output logic out_packet_ready_flag,
	output logic irq
);
	uoe_pkt_if pif ();
	logic rx_accept_c;

	uoe_pkt_queue u_queue (
		.hclk(hclk),
		.hresetn(hresetn),
		.dbuf_en(out_double_buffer_enable),
		// The accept strobe is registered, so the offer is still up one cycle after the take.
		// Masking it here keeps that one packet from being queued a second time.
		.rx_valid(rx_valid && !rx_accept),
		.rx_len(rx_len),
		.rx_accept(rx_accept_c),
		.pif(pif)
	);

	// Address phase capture
	logic wr_pend, next_wr_pend;
	logic rd_pend, next_rd_pend;
	logic [7:0] ph_idx, next_ph_idx;
	logic [7:0] ctrl_high, next_ctrl_high;
	logic [9:0] count_shadow, next_count_shadow;
	logic irq_status, next_irq_status;
	logic irq_enable, next_irq_enable;
	logic [31:0] next_hrdata;
	logic next_irq;
	logic release_c;
	logic addr_ok;
	logic [7:0] wbyte;

	always_comb begin
		addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
		next_wr_pend = addr_ok && hwrite;
		next_rd_pend = addr_ok && !hwrite;
		next_ph_idx = addr_ok ? haddr[9:2] : ph_idx;
		wbyte = hwdata[7:0];
		next_ctrl_high = ctrl_high;
		next_irq_enable = irq_enable;
		next_count_shadow = count_shadow;
		next_irq_status = irq_status;
		release_c = 1'b0;
		if (wr_pend) begin
			unique case (ph_idx)
				IDX_CONTROL_HIGH: next_ctrl_high = wbyte & CTRL_HIGH_MASK;
				// Writing zero to the ready bit hands the packet back to the queue
				IDX_PKT_STATUS: release_c = !wbyte[0] && pif.ready;
				IDX_IRQ_ENABLE: next_irq_enable = wbyte[IRQ_PKT_BIT];
				default: ;
			endcase
		end
		// Count loads in the same cycle the flag rises
		if (pif.set_pulse) begin
			next_count_shadow = pif.count;
		end
		// Hardware set wins over a software clear in the same cycle
		if (wr_pend && ph_idx == IDX_IRQ_CLEAR && wbyte[IRQ_PKT_BIT]) begin
			next_irq_status = 1'b0;
		end
		if (pif.set_pulse) begin
			next_irq_status = 1'b1;
		end
		next_irq = (next_irq_status && next_irq_enable);
		next_hrdata = 32'h00000000;
		if (next_rd_pend) begin
			unique case (haddr[9:2])
				IDX_CONTROL_HIGH: next_hrdata = {24'h000000, ctrl_high & CTRL_HIGH_MASK};
				IDX_COUNT_LOW: next_hrdata = {24'h000000, count_shadow[7:0]};
				IDX_COUNT_HIGH: next_hrdata = {30'h00000000, count_shadow[9:8]};
				IDX_PKT_STATUS: next_hrdata = {31'h00000000, pif.ready};
				IDX_IRQ_STATUS: next_hrdata = {31'h00000000, irq_status};
				IDX_IRQ_ENABLE: next_hrdata = {31'h00000000, irq_enable};
				default: next_hrdata = 32'h00000000;
			endcase
		end
	end

	assign pif.release_pkt = release_c;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			ph_idx <= 8'h00;
			ctrl_high <= CTRL_HIGH_RESET;
			count_shadow <= COUNT_RESET;
			irq_status <= 1'b0;
			irq_enable <= 1'b0;
			hrdata <= 32'h00000000;
			irq <= 1'b0;
			rx_accept <= 1'b0;
			out_double_buffer_enable <= 1'b0;
			out_iso_mode <= 1'b0;
			out_packet_ready_flag <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			ph_idx <= next_ph_idx;
			ctrl_high <= next_ctrl_high;
			count_shadow <= next_count_shadow;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			hrdata <= next_hrdata;
			irq <= next_irq;
			// Registered copy: the accept strobe lags the queue's take by one cycle
			rx_accept <= rx_accept_c;
			out_double_buffer_enable <= next_ctrl_high[DBUF_BIT];
			out_iso_mode <= next_ctrl_high[ISO_BIT];
			out_packet_ready_flag <= pif.ready;
			// Zero wait state, always OKAY
			hreadyout <= 1'b1;
			hresp <= OK_RESP[0];
		end
	end

	a_ctrl_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		ctrl_high[5:0] == 6'h00)
		else $error("control high low bits not zero");
	a_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend && ph_idx == IDX_CONTROL_HIGH) |=> ##1
		(out_double_buffer_enable == $past(hwdata[7], 2) && out_iso_mode == $past(hwdata[6], 2)))
		else $error("control write not reflected");
	a_count_low_rd: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr[9:2] == IDX_COUNT_LOW && !pif.set_pulse)
		|=> hrdata == {24'h000000, count_shadow[7:0]})
		else $error("count low read wrong");
	a_count_high_rd: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr[9:2] == IDX_COUNT_HIGH)
		|=> hrdata[31:2] == 30'h00000000)
		else $error("count high upper bits not zero");
	a_count_high_val: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr[9:2] == IDX_COUNT_HIGH && !pif.set_pulse)
		|=> hrdata[1:0] == count_shadow[9:8])
		else $error("count high bits wrong");
	a_count_load: assert property (@(posedge hclk) disable iff (!hresetn)
		pif.set_pulse |=> count_shadow == $past(pif.count))
		else $error("count not loaded with ready");
	a_ready_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		(pif.set_pulse && irq_enable && !(wr_pend && ph_idx == IDX_IRQ_ENABLE))
		|=> ##1 irq)
		else $error("interrupt not raised on packet ready");
	a_release_drops: assert property (@(posedge hclk) disable iff (!hresetn)
		(release_c && !pif.set_pulse && !rx_valid && !out_double_buffer_enable)
		|=> !pif.ready)
		else $error("ready did not fall after clear");
endmodule : uoe_endpoint_regs
`default_nettype wire

/* uoe_pkg.sv */
// Package: register map, field layout and reset values of the OUT endpoint config/count block
package uoe_pkg;
	// Printed offsets are not multiples of four: they are register indices, byte address = 4*index
	localparam logic [7:0] IDX_CONTROL_HIGH = 8'h15;
	localparam logic [7:0] IDX_COUNT_LOW = 8'h16;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h17;
	localparam logic [7:0] IDX_PKT_STATUS = 8'h18;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h19;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1A;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1B;
	localparam int DBUF_BIT = 7;
	localparam int ISO_BIT = 6;
	localparam logic [7:0] CTRL_HIGH_MASK = 8'hC0;
	localparam logic [7:0] CTRL_HIGH_RESET = 8'h00;
	localparam logic [9:0] COUNT_RESET = 10'h000;
	localparam int COUNT_W = 10;
	localparam int IRQ_PKT_BIT = 0;
	localparam logic [1:0] OK_RESP = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	function automatic logic [31:0] idx_to_addr(input logic [7:0] idx);
		idx_to_addr = {22'h000000, idx, 2'h0};
	endfunction
endpackage : uoe_pkg

/* uoe_pkt_if.sv */
// Interface: received packet handoff between the queue and the register bank
`timescale 1ns/1ps
`default_nettype none
interface uoe_pkt_if;
	logic ready;
	logic [9:0] count;
	logic release_pkt;
	logic set_pulse;
	modport queue (output ready, output count, output set_pulse, input release_pkt);
	modport bank (input ready, input count, input set_pulse, output release_pkt);
endinterface : uoe_pkt_if
`default_nettype wire

/* uoe_pkt_queue.sv */
// Two-slot received packet length queue that drives the packet-ready flag
`timescale 1ns/1ps
`default_nettype none
module uoe_pkt_queue
	import uoe_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic dbuf_en,
	input wire logic rx_valid,
	input wire logic [9:0] rx_len,
	output logic rx_accept,
	uoe_pkt_if.queue pif
);
	logic [9:0] slot0, slot1, next_slot0, next_slot1;
	logic [1:0] fill, next_fill;
	logic set_q, next_set;
	logic take;
	logic [1:0] cap;

	// Capacity follows the double-buffer enable; packets offered while full are refused unless a release comes in the same cycle
	always_comb begin
		cap = dbuf_en ? 2'h2 : 2'h1;
		take = rx_valid && (fill < cap || (pif.release_pkt && fill == cap));
		rx_accept = take;
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_fill = fill;
		next_set = 1'b0;
		if (pif.release_pkt && fill != 2'h0) begin
			next_slot0 = slot1;
			next_fill = fill - 2'h1;
		end
		if (take) begin
			if (next_fill == 2'h0) begin
				next_slot0 = rx_len;
			end else begin
				next_slot1 = rx_len;
			end
			next_fill = next_fill + 2'h1;
		end
		// Second held packet fires set_pulse again right after the clear; the ready flag stays up
		if (next_fill != 2'h0 && (fill == 2'h0 || pif.release_pkt)) begin
			next_set = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slot0 <= COUNT_RESET;
			slot1 <= COUNT_RESET;
			fill <= 2'h0;
			set_q <= 1'b0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			fill <= next_fill;
			set_q <= next_set;
		end
	end

	assign pif.ready = (fill != 2'h0);
	assign pif.count = slot0;
	assign pif.set_pulse = set_q;

	a_second_pkt_rearm: assert property (@(posedge hclk) disable iff (!hresetn)
		(pif.release_pkt && fill == 2'h2) |=> (pif.ready && set_q))
		else $error("second packet did not rearm ready flag");
endmodule : uoe_pkt_queue
`default_nettype wire

/* uoe_usb_host.sv */
// Partner model: USB host side offering received OUT packets to the bank
`timescale 1ns/1ps
`default_nettype none
module uoe_usb_host (
	input wire logic hclk,
	input wire logic rx_accept,
	output logic rx_valid,
	output logic [9:0] rx_len
);
	initial begin
		rx_valid = 1'b0;
		rx_len = 10'h155;
	end
	// Offer held until taken; released length is inverted so stale data never looks valid
	task automatic send(input logic [9:0] len);
		@(posedge hclk);
		rx_valid <= 1'b1;
		rx_len <= len;
		do @(posedge hclk); while (rx_accept !== 1'b1);
		rx_valid <= 1'b0;
		rx_len <= ~len;
	endtask
endmodule // uoe_usb_host
`default_nettype wire
